/* design/stt_timers.sv */
/*
 * System timers: a five-channel periodic tick timer with self-reloading
 * 32-bit down counters, and a task-monitor timer with a prescaled 32-bit
 * up counter and four compare channels. Registers sit on a classic
 * Wishbone slave.
 * Assumes one 50 MHz clock; the crystal rate arrives as a one-cycle
 * enable pulse xtal_tick_i, and stop and debug indications are levels
 * synchronous to clk_i. Events leave only as on-chip request lines.
 */
// Added by the designer: register access over Wishbone and the register addresses.
// Functional notes
// (R1) Five independent periodic channels with own outputs
// (R2) 32-bit down counters reload themselves at end
// (R3) Four channels system clocked, one crystal clocked
// (R4) Wake channel counts in stop, requests clock restart
// (R5) Zero raises interrupt or converter trigger as configured
// (R6) No pins; events go on-chip only
// (R7) Task counter 32-bit up, 8-bit prescaler
// (R8) Four 32-bit compare values against shared counter
// (R9) Compare passing raises processor interrupt
// (R10) Separate interrupt line per compare channel
// (R11) Optional halt in debug, resumes held value
// (R12) Zero reloads next cycle, sticky flag until cleared
// (R13) Task counter wraps all-ones to zero
`timescale 1ns/100ps
`include "stt_timers_regs.svh"

module stt_timers
    import stt_pkg::*;
(
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    // Wishbone slave
    input  wire stt_wb_req_t              wb_req_i,
    output stt_wb_rsp_t                   wb_rsp_o,
    // System state
    input  wire logic                     xtal_tick_i,
    input  wire logic                     stop_mode_i,
    input  wire logic                     debug_mode_i,
    // Periodic tick timer events
    output logic [STT_PIT_CHANS-1:0]      pit_irq_o,
    output logic [STT_PIT_CHANS-1:0]      pit_trig_o,
    output logic                          wake_req_o,
    // Task-monitor timer events
    output logic [STT_CMP_CHANS-1:0]      cmp_irq_o
);

    localparam logic [11:0] PIT_BASE = `STT_PIT_BASE;
    localparam logic [11:0] PIT_STRD = `STT_PIT_STRIDE;
    localparam logic [11:0] CMP_BASE = `STT_CMP_BASE;
    localparam logic [11:0] CMP_STRD = `STT_CMP_STRIDE;
    localparam int          WAKE_CH  = STT_PIT_CHANS - 1;

    ////////////////////////////////////////////////////////////////////////
    // State
    ////////////////////////////////////////////////////////////////////////
    logic                                  ack;
    logic                                  next_ack;
    logic [31:0]                           rdata;
    logic [31:0]                           next_rdata;

    logic [STT_PIT_CHANS-1:0][31:0]        pit_load;
    logic [STT_PIT_CHANS-1:0][31:0]        next_pit_load;
    logic [STT_PIT_CHANS-1:0][31:0]        pit_cnt;
    logic [STT_PIT_CHANS-1:0][31:0]        next_pit_cnt;
    stt_pit_ctrl_t [STT_PIT_CHANS-1:0]     pit_ctrl;
    stt_pit_ctrl_t [STT_PIT_CHANS-1:0]     next_pit_ctrl;
    logic [STT_PIT_CHANS-1:0]              pit_flag;
    logic [STT_PIT_CHANS-1:0]              next_pit_flag;
    logic [STT_PIT_CHANS-1:0]              pit_trig;
    logic [STT_PIT_CHANS-1:0]              next_pit_trig;
    logic                                  wake;
    logic                                  next_wake;

    logic                                  tc_en;
    logic                                  next_tc_en;
    logic                                  tc_frz;
    logic                                  next_tc_frz;
    logic [7:0]                            tc_ps;
    logic [7:0]                            next_tc_ps;
    logic [7:0]                            ps_cnt;
    logic [7:0]                            next_ps_cnt;
    logic [31:0]                           tc_cnt;
    logic [31:0]                           next_tc_cnt;
    logic [STT_CMP_CHANS-1:0][31:0]        cmp_val;
    logic [STT_CMP_CHANS-1:0][31:0]        next_cmp_val;
    logic [STT_CMP_CHANS-1:0]              cmp_en;
    logic [STT_CMP_CHANS-1:0]              next_cmp_en;
    logic [STT_CMP_CHANS-1:0]              cmp_flag;
    logic [STT_CMP_CHANS-1:0]              next_cmp_flag;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    ////////////////////////////////////////////////////////////////////////
    logic [11:0]                           adr;
    logic [11:0]                           pit_ofs;
    logic [11:0]                           cmp_ofs;
    logic                                  acc;
    logic                                  wr;
    logic                                  pit_hit;
    logic                                  cmp_hit;
    logic [2:0]                            pit_ch;
    logic [1:0]                            pit_reg;
    logic [1:0]                            cmp_ch;
    logic                                  cmp_reg;
    logic [31:0]                           wdat;

    assign adr     = wb_req_i.adr[11:0];
    assign acc     = wb_req_i.cyc & wb_req_i.stb;
    // A write commits on the edge that the master sees ack
    assign wr      = acc & wb_req_i.we & ack;
    assign pit_ofs = adr - PIT_BASE;
    assign cmp_ofs = adr - CMP_BASE;
    assign pit_hit = (adr >= PIT_BASE) && (adr < PIT_BASE + 12'(STT_PIT_CHANS) * PIT_STRD);
    assign cmp_hit = (adr >= CMP_BASE) && (adr < CMP_BASE + 12'(STT_CMP_CHANS) * CMP_STRD);
    assign pit_ch  = pit_ofs[6:4];
    assign pit_reg = pit_ofs[3:2];
    assign cmp_ch  = cmp_ofs[4:3];
    assign cmp_reg = cmp_ofs[2];

    // Byte lanes not selected keep the old contents
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                res[8*b +: 8] = dat[8*b +: 8];
            end
        end
        return res;
    endfunction

    // Write-one-to-clear masks for the sticky flags
    function automatic logic wr1(input logic [31:0] dat,
                                 input logic [3:0]  sel,
                                 input int          bit_no);
        return dat[bit_no] & sel[bit_no / 8];
    endfunction

    assign wdat = wb_req_i.dat;

    ////////////////////////////////////////////////////////////////////////
    // Bus answer: ack one cycle after the request, unmapped reads zero
    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_ack   = acc & ~ack;
        next_rdata = `STT_RST_WORD;
        if (pit_hit)
        begin
            case (pit_reg)
                `STT_PIT_LOAD_REG: next_rdata = pit_load[pit_ch];
                `STT_PIT_CURR_REG: next_rdata = pit_cnt[pit_ch];
                `STT_PIT_CTRL_REG: next_rdata = {29'h0, pit_ctrl[pit_ch]};
                default:           next_rdata = {31'h0, pit_flag[pit_ch]};
            endcase
        end
        else if (cmp_hit)
        begin
            next_rdata = cmp_reg ? cmp_val[cmp_ch] : {31'h0, cmp_en[cmp_ch]};
        end
        else if (adr == `STT_TC_CTRL_OFS)
        begin
            next_rdata[`STT_TC_EN_BIT]                  = tc_en;
            next_rdata[`STT_TC_FRZ_BIT]                 = tc_frz;
            next_rdata[`STT_TC_PS_MSB:`STT_TC_PS_LSB]   = tc_ps;
        end
        else if (adr == `STT_TC_COUNT_OFS)
        begin
            next_rdata = tc_cnt;
        end
        else if (adr == `STT_CMP_FLAG_OFS)
        begin
            next_rdata = {28'h0, cmp_flag};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Periodic tick timer
    ////////////////////////////////////////////////////////////////////////
    logic [STT_PIT_CHANS-1:0]              pit_tick;
    logic [STT_PIT_CHANS-1:0]              pit_zero;

    always_comb
    begin
        next_pit_load = pit_load;
        next_pit_cnt  = pit_cnt;
        next_pit_ctrl = pit_ctrl;
        next_pit_flag = pit_flag;
        next_pit_trig = '0;
        next_wake     = wake & stop_mode_i;
        pit_tick      = '0;
        pit_zero      = '0;
        for (int i = 0; i < STT_PIT_CHANS; i++)
        begin
            // System-clocked channels stop with the system clock
            if (i == WAKE_CH)
            begin
                pit_tick[i] = pit_ctrl[i].en & xtal_tick_i; // R3 R4
            end
            else
            begin
                pit_tick[i] = pit_ctrl[i].en & ~stop_mode_i; // R3
            end
            pit_zero[i] = pit_tick[i] && (pit_cnt[i] == 32'h0);
            if (pit_zero[i])
            begin
                next_pit_cnt[i] = pit_load[i]; // R2 R12
            end
            else if (pit_tick[i])
            begin
                next_pit_cnt[i] = pit_cnt[i] - 32'h1; // R1 R2
            end
            next_pit_trig[i] = pit_zero[i] & pit_ctrl[i].trg_en; // R5 R6
            // Set wins over a clear in the same cycle
            if (wr && pit_hit && pit_ch == 3'(i) && pit_reg == `STT_PIT_FLAG_REG
                && wr1(wdat, wb_req_i.sel, 0))
            begin
                next_pit_flag[i] = 1'b0;
            end
            if (pit_zero[i])
            begin
                next_pit_flag[i] = 1'b1; // R12
            end
            if (wr && pit_hit && pit_ch == 3'(i))
            begin
                if (pit_reg == `STT_PIT_LOAD_REG)
                begin
                    next_pit_load[i] = merge(pit_load[i], wdat, wb_req_i.sel);
                end
                else if (pit_reg == `STT_PIT_CTRL_REG && wb_req_i.sel[0])
                begin
                    next_pit_ctrl[i] = stt_pit_ctrl_t'(wdat[2:0]);
                    // Starting a channel begins a fresh period
                    if (wdat[0] && !pit_ctrl[i].en)
                    begin
                        next_pit_cnt[i] = pit_load[i];
                    end
                end
            end
        end
        if (pit_zero[WAKE_CH] && stop_mode_i)
        begin
            next_wake = 1'b1; // R4
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Task-monitor timer
    ////////////////////////////////////////////////////////////////////////
    logic                                  tc_run;
    logic                                  tc_tick;

    always_comb
    begin
        next_tc_en    = tc_en;
        next_tc_frz   = tc_frz;
        next_tc_ps    = tc_ps;
        next_ps_cnt   = ps_cnt;
        next_tc_cnt   = tc_cnt;
        next_cmp_val  = cmp_val;
        next_cmp_en   = cmp_en;
        next_cmp_flag = cmp_flag;
        // Freeze holds both the prescaler phase and the count
        tc_run  = tc_en & ~(tc_frz & debug_mode_i); // R11
        tc_tick = tc_run && (ps_cnt >= tc_ps);
        if (tc_run)
        begin
            next_ps_cnt = tc_tick ? 8'h00 : ps_cnt + 8'h01; // R7
        end
        if (tc_tick)
        begin
            next_tc_cnt = tc_cnt + 32'h1; // R7 R13
        end
        if (wr && adr == `STT_TC_CTRL_OFS)
        begin
            if (wb_req_i.sel[0])
            begin
                next_tc_en  = wdat[`STT_TC_EN_BIT];
                next_tc_frz = wdat[`STT_TC_FRZ_BIT];
            end
            if (wb_req_i.sel[1])
            begin
                next_tc_ps = wdat[`STT_TC_PS_MSB:`STT_TC_PS_LSB];
            end
        end
        if (wr && adr == `STT_TC_COUNT_OFS)
        begin
            next_tc_cnt = merge(tc_cnt, wdat, wb_req_i.sel);
        end
        for (int k = 0; k < STT_CMP_CHANS; k++)
        begin
            if (wr && cmp_hit && cmp_ch == 2'(k))
            begin
                if (cmp_reg)
                begin
                    next_cmp_val[k] = merge(cmp_val[k], wdat, wb_req_i.sel); // R8
                end
                else if (wb_req_i.sel[0])
                begin
                    next_cmp_en[k] = wdat[0];
                end
            end
            if (wr && adr == `STT_CMP_FLAG_OFS && wr1(wdat, wb_req_i.sel, k))
            begin
                next_cmp_flag[k] = 1'b0;
            end
            // The count moves past the compare value on this tick
            if (tc_tick && cmp_en[k] && tc_cnt == cmp_val[k])
            begin
                next_cmp_flag[k] = 1'b1; // R9 R10
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack      <= 1'b0;
            rdata    <= `STT_RST_WORD;
            pit_load <= '0;
            pit_cnt  <= '0;
            pit_ctrl <= '0;
            pit_flag <= '0;
            pit_trig <= '0;
            wake     <= 1'b0;
            tc_en    <= 1'b0;
            tc_frz   <= 1'b0;
            tc_ps    <= `STT_RST_PRESC;
            ps_cnt   <= 8'h00;
            tc_cnt   <= `STT_RST_WORD;
            cmp_val  <= '0;
            cmp_en   <= '0;
            cmp_flag <= '0;
        end
        else
        begin
            ack      <= next_ack;
            rdata    <= next_rdata;
            pit_load <= next_pit_load;
            pit_cnt  <= next_pit_cnt;
            pit_ctrl <= next_pit_ctrl;
            pit_flag <= next_pit_flag;
            pit_trig <= next_pit_trig;
            wake     <= next_wake;
            tc_en    <= next_tc_en;
            tc_frz   <= next_tc_frz;
            tc_ps    <= next_tc_ps;
            ps_cnt   <= next_ps_cnt;
            tc_cnt   <= next_tc_cnt;
            cmp_val  <= next_cmp_val;
            cmp_en   <= next_cmp_en;
            cmp_flag <= next_cmp_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        wb_rsp_o.ack = ack;
        wb_rsp_o.dat = rdata;
        for (int i = 0; i < STT_PIT_CHANS; i++)
        begin
            pit_irq_o[i] = pit_flag[i] & pit_ctrl[i].irq_en; // R5
        end
    end

    assign pit_trig_o = pit_trig;
    assign wake_req_o = wake;
    assign cmp_irq_o  = cmp_flag; // R10

endmodule

/* design/stt_timers_regs.svh */
/*
 * Register offsets, field positions and reset values of the system timers.
 * Assumes a 32-bit classic Wishbone slave decoding byte address bits [11:0].
 */
`ifndef STT_TIMERS_REGS_SVH
`define STT_TIMERS_REGS_SVH

// Task-monitor timer
`define STT_TC_CTRL_OFS     12'h000
`define STT_TC_COUNT_OFS    12'h004
`define STT_CMP_FLAG_OFS    12'h008
`define STT_CMP_BASE        12'h020
`define STT_CMP_STRIDE      12'h008
`define STT_TC_EN_BIT       0
`define STT_TC_FRZ_BIT      1
`define STT_TC_PS_LSB       8
`define STT_TC_PS_MSB       15

// Periodic tick timer, one 16-byte block per channel
`define STT_PIT_BASE        12'h100
`define STT_PIT_STRIDE      12'h010
`define STT_PIT_LOAD_REG    2'h0
`define STT_PIT_CURR_REG    2'h1
`define STT_PIT_CTRL_REG    2'h2
`define STT_PIT_FLAG_REG    2'h3

// Reset values
`define STT_RST_WORD        32'h0000_0000
`define STT_RST_PRESC       8'h00

`endif

/* design/stt_pkg.sv */
/*
 * Types shared by the system timers block.
 * Assumes a 32-bit classic Wishbone bus on the register side.
 */
package stt_pkg;

    localparam int STT_PIT_CHANS = 5;
    localparam int STT_CMP_CHANS = 4;

    typedef struct packed {
        logic [31:0] adr;
        logic [31:0] dat;
        logic [3:0]  sel;
        logic        we;
        logic        cyc;
        logic        stb;
    } stt_wb_req_t;

    typedef struct packed {
        logic [31:0] dat;
        logic        ack;
    } stt_wb_rsp_t;

    // Periodic channel control word, bit 0 is the enable
    typedef struct packed {
        logic trg_en;
        logic irq_en;
        logic en;
    } stt_pit_ctrl_t;

endpackage

/* dv/stt_timers_assertions.sv */
/* Checker for the system timers: bus handshake, event lines and wake request.
   Assumes it is bound to stt_timers, one clock, synchronous active-high reset. */
`timescale 1ns/100ps
module stt_timers_assertions
    import stt_pkg::*;
(
    // Clock and reset
    input wire logic                     clk_i,
    input wire logic                     rst_i,
    // Bus
    input wire stt_wb_req_t              wb_req_i,
    input wire stt_wb_rsp_t              wb_rsp_o,
    // System state
    input wire logic                     xtal_tick_i,
    input wire logic                     stop_mode_i,
    input wire logic                     debug_mode_i,
    // Events
    input wire logic [STT_PIT_CHANS-1:0] pit_irq_o,
    input wire logic [STT_PIT_CHANS-1:0] pit_trig_o,
    input wire logic                     wake_req_o,
    input wire logic [STT_CMP_CHANS-1:0] cmp_irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_ACK_ANSWER: assert property ((wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack)
        |=> wb_rsp_o.ack) else $error("bus request not acked in next cycle");
    AST_ACK_PULSE: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack held longer than one cycle");
    AST_ACK_CAUSE: assert property (wb_rsp_o.ack |-> $past(wb_req_i.cyc && wb_req_i.stb))
        else $error("ack without a request");
    AST_TRIG_STOP: assert property (stop_mode_i [*2] |-> pit_trig_o[3:0] == 4'h0)
        else $error("system clocked channel triggered in stop mode");
    AST_TRIG_XTAL: assert property (pit_trig_o[4] |-> ($past(xtal_tick_i)
        || $past(xtal_tick_i, 2))) else $error("wake channel trigger without crystal tick");
    AST_PIT_STICKY: assert property ((|($past(pit_irq_o) & ~pit_irq_o))
        |-> $past(wb_rsp_o.ack && wb_req_i.we)) else $error("periodic request fell alone");
    AST_CMP_STICKY: assert property ((|($past(cmp_irq_o) & ~cmp_irq_o))
        |-> $past(wb_rsp_o.ack && wb_req_i.we)) else $error("compare request fell alone");
    AST_WAKE_RISE: assert property ($rose(wake_req_o) |-> $past(stop_mode_i))
        else $error("wake request outside stop mode");
    AST_WAKE_CLEAR: assert property (!stop_mode_i [*3] |-> !wake_req_o)
        else $error("wake request held after stop mode ended");
endmodule

bind stt_timers stt_timers_assertions u_stt_timers_assertions (.clk_i(clk_i), .rst_i(rst_i),
    .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .xtal_tick_i(xtal_tick_i),
    .stop_mode_i(stop_mode_i), .debug_mode_i(debug_mode_i), .pit_irq_o(pit_irq_o),
    .pit_trig_o(pit_trig_o), .wake_req_o(wake_req_o), .cmp_irq_o(cmp_irq_o));

/* dv/stt_event_sink.sv */
/* Model of the converter queues that take the trigger events.
   Assumes event lines synchronous to clk_i; counts every trigger pulse. */
`timescale 1ns/100ps
module stt_event_sink
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Events
    input  wire logic [4:0]  trig_i,
    // Tally
    output logic      [15:0] trig_total_o
);
    // Each high cycle is one queue start, so a stretched pulse shows as extra starts
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            trig_total_o <= 16'h0000;
        else
            trig_total_o <= trig_total_o + 16'($countones(trig_i));
    end
endmodule

/* dv/stt_timers_tb.sv */
/* Self-checking bench for the system timers over classic Wishbone.
   Assumes the crystal tick is one pulse every seven system clocks. */
`timescale 1ns/100ps
`include "stt_timers_regs.svh"
module stt_timers_tb;
    import stt_pkg::*;
    logic clk_i, rst_i, xtal_tick, stop_mode, debug_mode, wake_req;
    stt_wb_req_t wb_req;
    stt_wb_rsp_t wb_rsp;
    logic [4:0]  pit_irq, pit_trig;
    logic [3:0]  cmp_irq;
    logic [15:0] trig_total, t0;
    logic [31:0] q, q2;
    int          mismatches, total_checks, cycles, xdiv, n, i;

    stt_timers u_stt_timers (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req),
        .wb_rsp_o(wb_rsp), .xtal_tick_i(xtal_tick), .stop_mode_i(stop_mode),
        .debug_mode_i(debug_mode), .pit_irq_o(pit_irq), .pit_trig_o(pit_trig),
        .wake_req_o(wake_req), .cmp_irq_o(cmp_irq));
    stt_event_sink u_stt_event_sink (.clk_i(clk_i), .rst_i(rst_i), .trig_i(pit_trig),
        .trig_total_o(trig_total));

    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Entered just after a rising edge; ends one idle edge after the ack edge
    task automatic wb(input logic [31:0] a, input logic [31:0] d, input logic w);
        int k;
        k = 0;
        wb_req <= '{adr: a, dat: d, sel: 4'hf, we: w, cyc: 1'b1, stb: 1'b1};
        do
        begin
            @(posedge clk_i);
            k++;
        end while (wb_rsp.ack !== 1'b1 && k < 50);
        if (k >= 50)
            mismatches++;
        q = wb_rsp.dat;
        wb_req <= '0;
        @(posedge clk_i);
    endtask

    function automatic logic [31:0] pa(input int ch, input int r);
        return 32'(`STT_PIT_BASE + ch * `STT_PIT_STRIDE + r * 4);
    endfunction

    // Clocks between two successive trigger pulses of one channel
    task automatic trig_gap(input int ch);
        repeat (2)
        begin
            n = 0;
            do
            begin
                @(posedge clk_i);
                n++;
            end while (pit_trig[ch] !== 1'b1 && n < 400);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_i)
    begin
        xdiv <= (xdiv == 6) ? 0 : xdiv + 1;
        xtal_tick <= (xdiv == 6);
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches++;
            close_out();
        end
    end

    initial
    begin
        {rst_i, xtal_tick, stop_mode, debug_mode} = 4'h8;
        wb_req = '0;
        {xdiv, cycles, mismatches, total_checks} = '0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        // Reset values, unmapped place, read-only current count
        wb(`STT_TC_CTRL_OFS, 0, 0);
        chk(q, `STT_RST_WORD);
        wb(32'h0000_00fc, 32'hffff_ffff, 1);
        wb(32'h0000_00fc, 0, 0);
        chk(q, 32'h0000_0000);
        wb(pa(1, 1), 32'h0000_0005, 1);
        wb(pa(1, 1), 0, 0);
        chk(q, 32'h0000_0000);
        $display("test regs done");
        // Period of every channel, flag and request, clear
        for (i = 0; i < 5; i++)
        begin
            wb(pa(i, 0), 32'(i + 2), 1);
            wb(pa(i, 2), 32'h0000_0007, 1);
            trig_gap(i);
            chk(32'(n), (i < 4) ? 32'(i + 3) : 32'((i + 3) * 7));
            chk(pit_irq[i], 1'b1);
            wb(pa(i, 2), 32'h0000_0002, 1);
            wb(pa(i, 3), 0, 0);
            chk(q, 32'h0000_0001);
            wb(pa(i, 3), 32'h0000_0001, 1);
            chk(pit_irq[i], 1'b0);
        end
        // Events off by configuration, flag still kept
        wb(pa(0, 2), 32'h0000_0001, 1);
        t0 = trig_total;
        repeat (20) @(posedge clk_i);
        chk(trig_total, t0);
        chk(pit_irq[0], 1'b0);
        wb(pa(0, 3), 0, 0);
        chk(q, 32'h0000_0001);
        $display("test periodic done");
        // Stop mode: system channel 0 holds, wake channel runs and raises wake
        wb(pa(0, 2), 32'h0000_0007, 1);
        wb(pa(4, 0), 32'h0000_0001, 1);
        wb(pa(4, 2), 32'h0000_0001, 1);
        stop_mode <= 1'b1;
        repeat (2) @(posedge clk_i);
        t0 = trig_total;
        repeat (40) @(posedge clk_i);
        chk(trig_total, t0);
        chk(wake_req, 1'b1);
        stop_mode <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk(wake_req, 1'b0);
        wb(pa(0, 2), 0, 1);
        wb(pa(4, 2), 0, 1);
        $display("test stop done");
        // Compares just below the wrap, each on its own line
        for (i = 0; i < 4; i++)
        begin
            wb(32'(`STT_CMP_BASE + i * 8 + 4), 32'hffff_fffc + 32'(i), 1);
            wb(32'(`STT_CMP_BASE + i * 8), 32'h0000_0001, 1);
        end
        wb(`STT_TC_COUNT_OFS, 32'hffff_fff0, 1);
        wb(`STT_TC_CTRL_OFS, 32'h0000_0001, 1);
        repeat (30) @(posedge clk_i);
        wb(`STT_TC_CTRL_OFS, 0, 1);
        chk(cmp_irq, 4'hf);
        wb(`STT_TC_COUNT_OFS, 0, 0);
        chk(32'(q < 32'h0000_0040), 32'h0000_0001);
        wb(`STT_CMP_FLAG_OFS, 32'h0000_0003, 1);
        chk(cmp_irq, 4'hc);
        wb(`STT_CMP_FLAG_OFS, 32'h0000_000f, 1);
        chk(cmp_irq, 4'h0);
        // Prescaler 3: one count per four clocks
        wb(`STT_TC_COUNT_OFS, 0, 1);
        wb(`STT_TC_CTRL_OFS, 32'h0000_0301, 1);
        repeat (40) @(posedge clk_i);
        wb(`STT_TC_CTRL_OFS, 0, 1);
        wb(`STT_TC_COUNT_OFS, 0, 0);
        chk(32'(q >= 32'h0000_0009 && q <= 32'h0000_000b), 32'h0000_0001);
        // Freeze in debug, resume from held value
        debug_mode <= 1'b1;
        wb(`STT_TC_CTRL_OFS, 32'h0000_0003, 1);
        wb(`STT_TC_COUNT_OFS, 0, 0);
        q2 = q;
        repeat (5) @(posedge clk_i);
        wb(`STT_TC_COUNT_OFS, 0, 0);
        chk(q, q2);
        debug_mode <= 1'b0;
        repeat (5) @(posedge clk_i);
        wb(`STT_TC_COUNT_OFS, 0, 0);
        chk(32'(q > q2 && q < q2 + 32'h0000_0010), 32'h0000_0001);
        // Freeze bit clear: the counter keeps running through debug
        debug_mode <= 1'b1;
        wb(`STT_TC_CTRL_OFS, 32'h0000_0001, 1);
        wb(`STT_TC_COUNT_OFS, 0, 0);
        q2 = q;
        repeat (5) @(posedge clk_i);
        wb(`STT_TC_COUNT_OFS, 0, 0);
        chk(32'(q > q2), 32'h0000_0001);
        debug_mode <= 1'b0;
        wb(`STT_TC_CTRL_OFS, 0, 1);
        $display("test task timer done");
        close_out();
    end
endmodule
